// >>> common/sbgt_pkg.sv
package sbgt_pkg;

	// ----------------------------------------
	// clock selection encodings
	// ----------------------------------------
	localparam logic [1:0] SBGT_CS_INSTR = 2'h0;
	localparam logic [1:0] SBGT_CS_SYS = 2'h1;
	localparam logic [1:0] SBGT_CS_EXT = 2'h2;
	localparam logic [1:0] SBGT_CS_LFOSC = 2'h3;

	// ----------------------------------------
	// counts and reset values
	// ----------------------------------------
	localparam logic [1:0] SBGT_INSTR_DIV_LAST = 2'h3;
	localparam logic [15:0] SBGT_COUNT_RST = 16'h0000;
	localparam logic [15:0] SBGT_COUNT_MAX = 16'hFFFF;
	localparam logic [2:0] SBGT_PRE_RST = 3'h0;
	localparam logic [1:0] SBGT_FIELD_RST = 2'h0;
	localparam int SBGT_BYTE_W = 8;

	typedef struct packed {
		logic run_bit;
		logic gate_enable_bit;
		logic gate_polarity_bit;
		logic [1:0] clock_select_field;
		logic osc_enable_bit;
		logic [1:0] prescale_field;
		logic sync_disable_bit;
	} sbgt_ctrl_s;

	typedef struct packed {
		logic [15:0] count;
		logic [2:0] pre;
		logic [1:0] instr_div;
		logic overflow_flag;
		logic overflow_pulse;
		logic armed;
		logic ext_s1;
		logic ext_s2;
		logic ext_s3;
		logic ext_prev;
		logic lf_s1;
		logic lf_s2;
		logic lf_prev;
		logic gate_s1;
		logic gate_s2;
	} sbgt_state_s;

endpackage

// >>> rtl/sbgt_timer.sv
// Functional notes
// - 16-bit up counter; writing either byte loads that byte at once.
// - instruction clock source increments once per instruction cycle.
// - run bit 0 stops; run 1 counts freely or only when gate permits.
// - select 11 low-freq osc, 10 ext pin, 01 system clock, 00 sys/4.
// - system clock source gives four counts per instruction cycle.
// - external source counts on rising edges of the external clock pin.
// - external clock may be synchronised or unsynchronised.
// - counter mode needs a falling edge before the first counting rising edge.
// - prescale field divides the chosen clock by 1, 2, 4 or 8.
// - prescaler is hidden from software and cleared on any count write.
// - sync disable bit bypasses the ext_s3 retiming stage; the two input flops stay in the path.
// - asynchronous external mode keeps counting in sleep; overflow wakes.
// - switching sync mode may lose or add one count.
// - rollover from all ones to zero sets a sticky overflow flag.
// - gated counting only while gate level equals gate polarity.
`timescale 1ns/1ps
module sbgt_timer
	import sbgt_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic run_bit_in,
	input wire logic gate_enable_bit_in,
	input wire logic gate_polarity_bit_in,
	input wire logic [1:0] clock_select_field_in,
	input wire logic osc_enable_bit_in,
	input wire logic [1:0] prescale_field_in,
	input wire logic sync_disable_bit_in,
	input wire logic sleep_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_high_in,
	input wire logic wr_low_in,
	input wire logic flag_clear_in,
	input wire logic ext_clock_pin_in,
	input wire logic gate_pin_in,
	input wire logic low_freq_internal_osc_in,
	output logic [7:0] count_high_byte_out,
	output logic [7:0] count_low_byte_out,
	output logic overflow_flag_out,
	output logic overflow_pulse_out,
	output logic wake_out
);

	sbgt_ctrl_s ctrl;
	sbgt_state_s state_reg;
	sbgt_state_s state_next;
	sbgt_ctrl_s ctrl_reg;
	logic wake_reg;
	logic wake_next;
	logic ext_edge_async;
	logic ext_rise;
	logic ext_fall;
	logic lf_rise;
	logic gate_ok;
	logic src_tick;
	logic pre_tick;
	logic [2:0] pre_mask;
	logic ext_sel;
	logic counting;

	always_comb begin
		ctrl.run_bit = run_bit_in;
		ctrl.gate_enable_bit = gate_enable_bit_in;
		ctrl.gate_polarity_bit = gate_polarity_bit_in;
		ctrl.clock_select_field = clock_select_field_in;
		ctrl.osc_enable_bit = osc_enable_bit_in;
		ctrl.prescale_field = prescale_field_in;
		ctrl.sync_disable_bit = sync_disable_bit_in;
	end

	// ----------------------------------------
	// source and enable decode
	// ----------------------------------------
	// async path skips the retiming stage ext_s3 but still sits behind two flops;
	// it saves one cycle of latency, which is what makes sync switches slip a count
	assign ext_edge_async = state_reg.ext_s2;
	always_comb begin
		ext_sel = (ctrl_reg.clock_select_field == SBGT_CS_EXT) && !ctrl_reg.osc_enable_bit;
		if (ctrl_reg.sync_disable_bit) begin
			ext_rise = ext_edge_async && !state_reg.ext_s3;
			ext_fall = !ext_edge_async && state_reg.ext_s3;
		end else begin
			ext_rise = state_reg.ext_s3 && !state_reg.ext_prev;
			ext_fall = !state_reg.ext_s3 && state_reg.ext_prev;
		end
		lf_rise = state_reg.lf_s2 && !state_reg.lf_prev;
		gate_ok = (state_reg.gate_s2 == ctrl_reg.gate_polarity_bit);
		counting = ctrl_reg.run_bit && (!ctrl_reg.gate_enable_bit || gate_ok);
		case (ctrl_reg.clock_select_field)
			SBGT_CS_INSTR: src_tick = (state_reg.instr_div == SBGT_INSTR_DIV_LAST);
			SBGT_CS_SYS: src_tick = 1'b1;
			SBGT_CS_EXT: src_tick = ext_sel && ext_rise && state_reg.armed;
			SBGT_CS_LFOSC: src_tick = lf_rise;
			default: src_tick = 1'b0;
		endcase
		case (ctrl_reg.prescale_field)
			2'h0: pre_mask = 3'h0;
			2'h1: pre_mask = 3'h1;
			2'h2: pre_mask = 3'h3;
			default: pre_mask = 3'h7;
		endcase
		pre_tick = counting && src_tick && ((state_reg.pre & pre_mask) == pre_mask);
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		state_next.ext_s1 = ext_clock_pin_in;
		state_next.ext_s2 = state_reg.ext_s1;
		state_next.ext_s3 = state_reg.ext_s2;
		state_next.ext_prev = state_reg.ext_s3;
		state_next.lf_s1 = low_freq_internal_osc_in;
		state_next.lf_s2 = state_reg.lf_s1;
		state_next.lf_prev = state_reg.lf_s2;
		state_next.gate_s1 = gate_pin_in;
		state_next.gate_s2 = state_reg.gate_s1;
		state_next.overflow_pulse = 1'b0;
		// instruction phase runs freely, like the core's phase clocks
		state_next.instr_div = state_reg.instr_div + 2'h1;
		// only sleep freezes the synchronous paths; async external keeps going
		if (!sleep_in || (ext_sel && ctrl_reg.sync_disable_bit)) begin
			if (counting && src_tick) begin
				state_next.pre = (state_reg.pre & pre_mask) == pre_mask ? SBGT_PRE_RST : state_reg.pre + 3'h1;
			end
			if (pre_tick) begin
				state_next.count = state_reg.count + 16'h0001;
				if (state_reg.count == SBGT_COUNT_MAX) begin
					state_next.overflow_pulse = 1'b1;
				end
			end
		end
		// a falling edge re-arms; disable or write disarms
		if (!ctrl_reg.run_bit) begin
			state_next.armed = 1'b0;
		end else if (ext_fall) begin
			state_next.armed = 1'b1;
		end
		// a write wins for the byte it writes; the other byte and the overflow pulse still take a concurrent increment
		if (wr_high_in) begin
			state_next.count[15:8] = wr_data_in;
		end
		if (wr_low_in) begin
			state_next.count[7:0] = wr_data_in;
		end
		if (wr_high_in || wr_low_in) begin
			state_next.pre = SBGT_PRE_RST;
			state_next.armed = 1'b0;
		end
		// set beats clear in the same cycle
		if (flag_clear_in) begin
			state_next.overflow_flag = 1'b0;
		end
		if (state_next.overflow_pulse) begin
			state_next.overflow_flag = 1'b1;
		end
		wake_next = state_next.overflow_pulse && sleep_in;
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_reg <= '0;
			state_reg.count <= SBGT_COUNT_RST;
			state_reg.pre <= SBGT_PRE_RST;
			ctrl_reg <= '0;
			wake_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl;
			wake_reg <= wake_next;
		end
	end

	assign count_high_byte_out = state_reg.count[15:8];
	assign count_low_byte_out = state_reg.count[7:0];
	assign overflow_flag_out = state_reg.overflow_flag;
	assign overflow_pulse_out = state_reg.overflow_pulse;
	assign wake_out = wake_reg;

endmodule

// >>> test/sbgt_pin_source.sv
`timescale 1ns/1ps
module sbgt_pin_source (
	output logic ext_clock_pin_out,
	output logic gate_pin_out
);
	// clock pin stands low between bursts, never free-runs
	initial begin
		ext_clock_pin_out = 1'h0;
		gate_pin_out = 1'h0;
	end
	task automatic pulses(input int n);
		repeat (n) begin
			#700 ext_clock_pin_out = 1'h1;
			#700 ext_clock_pin_out = 1'h0;
		end
	endtask
	task automatic set_gate(input logic v);
		gate_pin_out = v;
	endtask
endmodule

// >>> test/sbgt_timer_monitor.sv
`timescale 1ns/1ps
module sbgt_timer_monitor (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic run_bit_in,
	input wire logic sleep_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_high_in,
	input wire logic wr_low_in,
	input wire logic flag_clear_in,
	input wire logic [7:0] count_high_byte_out,
	input wire logic [7:0] count_low_byte_out,
	input wire logic overflow_flag_out,
	input wire logic overflow_pulse_out,
	input wire logic wake_out
);
	wire logic [15:0] c = {count_high_byte_out, count_low_byte_out};
	wire logic nw = !wr_high_in && !wr_low_in;
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	low_load_a: assert property (
		wr_low_in |=> count_low_byte_out == $past(wr_data_in)) else $error("low byte load wrong");
	high_load_a: assert property (
		wr_high_in |=> count_high_byte_out == $past(wr_data_in)) else $error("high byte load wrong");
	off_hold_a: assert property (
		(!run_bit_in && nw)[*3] |=> $stable(c)) else $error("counted while off");
	wrap_pulse_a: assert property (
		(c == 16'hFFFF && nw ##1 c == 16'h0000) |-> ##[0:1] overflow_pulse_out) else $error("no wrap pulse");
	pulse_flag_a: assert property (
		overflow_pulse_out |-> ##[0:1] overflow_flag_out) else $error("flag not set");
	flag_sticky_a: assert property (
		overflow_flag_out && !flag_clear_in |=> overflow_flag_out) else $error("flag dropped");
	pulse_single_a: assert property (
		overflow_pulse_out |=> !overflow_pulse_out) else $error("pulse too long");
	wake_cause_a: assert property (
		wake_out |-> overflow_pulse_out) else $error("wake without wrap");
	sleep_wake_a: assert property (
		overflow_pulse_out && $past(sleep_in) |-> wake_out) else $error("no wake on wrap in sleep");
endmodule
bind sbgt_timer sbgt_timer_monitor mon (.clk_in, .rst_in, .run_bit_in, .sleep_in, .wr_data_in, .wr_high_in,
	.wr_low_in, .flag_clear_in, .count_high_byte_out, .count_low_byte_out, .overflow_flag_out, .overflow_pulse_out,
	.wake_out);

// >>> test/tb_sbgt_timer.sv
`timescale 1ns/1ps
module tb_sbgt_timer
	import sbgt_pkg::*;
;
	logic clk_in = 1'h0, rst_in = 1'h1, run = 1'h0, ge = 1'h0, sd = 1'h0, slp = 1'h0;
	logic wh = 1'h0, wl = 1'h0, fc = 1'h0, lf = 1'h0, woke = 1'h0, gpol = 1'h1, oe = 1'h0;
	logic [1:0] cs = 2'h0, ps = 2'h0;
	logic [7:0] wd = 8'h00, hi, lo;
	logic fl, pu, wk, xp, gp;
	logic [15:0] c0;
	int num_errors = 0, check_count = 0;
	sbgt_pin_source src (.ext_clock_pin_out(xp), .gate_pin_out(gp));
	sbgt_timer uut (.clk_in, .rst_in, .run_bit_in(run), .gate_enable_bit_in(ge), .gate_polarity_bit_in(gpol),
		.clock_select_field_in(cs), .osc_enable_bit_in(oe), .prescale_field_in(ps), .sync_disable_bit_in(sd),
		.sleep_in(slp), .wr_data_in(wd), .wr_high_in(wh), .wr_low_in(wl), .flag_clear_in(fc),
		.ext_clock_pin_in(xp), .gate_pin_in(gp), .low_freq_internal_osc_in(lf), .count_high_byte_out(hi),
		.count_low_byte_out(lo), .overflow_flag_out(fl), .overflow_pulse_out(pu), .wake_out(wk));
	initial forever #50 clk_in = ~clk_in;
	always #1600 lf = ~lf;
	always @(posedge clk_in) if (wk) woke <= 1'h1;
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [15:0] v);
		@(negedge clk_in) {wl, wd} = {1'h1, v[7:0]};
		@(negedge clk_in) {wl, wh, wd} = {1'h0, 1'h1, v[15:8]};
		@(negedge clk_in) wh = 1'h0;
	endtask
	// 32-cycle window is a whole number of every divider period
	task automatic rate(input logic [1:0] s, input logic [1:0] p, input logic [15:0] e);
		@(negedge clk_in) {cs, ps} = {s, p};
		repeat (6) @(negedge clk_in);
		c0 = {hi, lo};
		repeat (32) @(negedge clk_in);
		chk({hi, lo} - c0, e);
	endtask
	task automatic summarize;
		$display("comparisons %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		@(negedge clk_in) rst_in = 1'h0;
		chk({hi, lo}, 16'h0000);
		wr(16'hA55A);
		chk({hi, lo}, 16'hA55A);
		$display("load test done");
		run = 1'h1;
		for (int i = 0; i < 4; i++) rate(SBGT_CS_SYS, i[1:0], 16'h20 >> i);
		rate(SBGT_CS_INSTR, 2'h0, 16'h8);
		rate(SBGT_CS_LFOSC, 2'h0, 16'h1);
		ge = 1'h1;
		rate(SBGT_CS_SYS, 2'h0, 16'h0);
		src.set_gate(1'h1);
		rate(SBGT_CS_SYS, 2'h0, 16'h20);
		gpol = 1'h0;
		rate(SBGT_CS_SYS, 2'h0, 16'h0);
		run = 1'h0;
		rate(SBGT_CS_SYS, 2'h0, 16'h0);
		$display("rate test done");
		for (int s = 0; s < 2; s++) begin
			@(negedge clk_in) {run, cs, sd, ge} = {1'h1, SBGT_CS_EXT, s[0], 1'h0};
			wr(16'h0000);
			src.pulses(3);
			repeat (4) @(negedge clk_in);
			chk({hi, lo}, 16'h0002);
		end
		// osc enable set blocks the pin source
		@(negedge clk_in) oe = 1'h1;
		src.pulses(3);
		repeat (4) @(negedge clk_in);
		chk({hi, lo}, 16'h0002);
		oe = 1'h0;
		wr(16'hFFFF);
		slp = 1'h1;
		src.pulses(2);
		repeat (4) @(negedge clk_in);
		chk({hi, lo}, 16'h0000);
		chk({14'h0000, fl, woke}, 16'h0003);
		{slp, fc} = 2'h1;
		@(negedge clk_in) fc = 1'h0;
		@(negedge clk_in) chk({15'h0000, fl}, 16'h0000);
		$display("pin test done");
		summarize();
	end
	initial begin
		#400000;
		num_errors++;
		summarize();
	end
endmodule
